/* File: design/fhc_pkg.sv */
// Package for the frame header control octet builder and checker
package fhc_pkg;

   // =====================================================
   // Header constants
   localparam logic [7:0]  FHC_SYNC1    = 8'hf6;
   localparam logic [7:0]  FHC_SYNC2    = 8'h28;
   localparam logic [23:0] FHC_CRC_MASK = 24'hff7e7e;
   localparam logic [3:0]  FHC_CRC_POLY = 4'h3;
   localparam int          FHC_HDR_LEN  = 5;

   // =====================================================
   // Register map
   localparam int          FHC_AW       = 8;
   localparam logic [7:0]  FHC_CTRL     = 8'h00;
   localparam logic [7:0]  FHC_TX_IND   = 8'h04;
   localparam logic [7:0]  FHC_RX_IND   = 8'h08;
   localparam logic [7:0]  FHC_STATUS   = 8'h0c;
   localparam logic [7:0]  FHC_ERR_CNT  = 8'h10;
   localparam logic [7:0]  FHC_GOOD_CNT = 8'h14;
   localparam int          FHC_CTRL_W   = 4;
   localparam int          FHC_IND_W    = 18;
   localparam int          FHC_CNT_W    = 16;
   localparam logic [3:0]  FHC_CTRL_RST = 4'h0;

   // =====================================================
   // Indicator fields carried by the control octets
   typedef struct packed {
      logic       trig;
      logic       ack;
      logic       path_one_fault;
      logic       path_two_fault;
      logic       path_three_fault;
      logic       path_four_fault;
      logic       far_signal_loss;
      logic       far_carrier_one_loss;
      logic       far_carrier_two_loss;
      logic       far_frame_defect;
      logic       far_power_off;
      logic       far_power_loss;
      logic [1:0] extra_fault;
      logic [3:0] prop;
   } fhc_ind_t;

   typedef struct packed {
      logic remote_side;
      logic cell_mode;
      logic dual_latency;
      logic extra_en;
   } fhc_cfg_t;

   // =====================================================
   // Header check: message times D^4 modulo D^4 + D + 1
   function automatic logic [3:0] fhc_crc(input logic [23:0] msg);
      logic [3:0] r;
      logic       fb;
      r = 4'h0;
      for (int k = 23; k >= 0; k--) begin
         fb = r[3] ^ msg[k];
         r  = {r[2:0], 1'b0} ^ (fb ? FHC_CRC_POLY : 4'h0);
      end
      return r;
   endfunction : fhc_crc

endpackage : fhc_pkg

/* File: design/fhc_top.sv */
// Frame header control octet builder, checker and APB register file
//
// Contract
// RL1: Octet one bit 0 carries the activation trigger, 1 when active.
// RL2: Octet one bit 1 carries the activation acknowledge flag.
// RL3: Octet one bits 2 to 5 are path one to four fault flags.
// RL4: Octet one bit 6 is reserved and always sent as zero.
// RL5: Octet one bit 7 is 1 only in frames carrying the timing marker.
// RL6: Every indicator is 0 for normal and 1 for fault.
// RL7: Extra path failures may use spare bits of octets one and two.
// RL8: Cell mode: path one shows slow cell loss, dual adds fast on two.
// RL9: Octet two holds check bit one at bit 0, two at bit 7.
// RL10: Octet two bits 1 to 3: signal, carrier one, carrier two loss.
// RL11: Octet two bit 4 reports the severely errored frame defect.
// RL12: Octet two bits 5 and 6 carry no defined indication.
// RL13: Octet three holds check bit three at bit 0, four at bit 7.
// RL14: Octet three bit 1 reports far power-off failure.
// RL15: Octet three bit 2 reports dying gasp, set only by remote side.
// RL16: Octet three bits 3 to 6 are proprietary.
// RL17: Check bits are remainder of message times D^4 by D^4+D+1.
// RL18: Message runs octet one MSB to octet three LSB, check bits zero.
// RL19: Remainder MSB goes to check bit one, LSB to check bit four.
// RL20: Bit 0 is the octet MSB and is sent first.
// RL21: Control octets follow sync octets f6 and 28 at positions 2 to 4.
// RL22: Receiver discards indicators whose recomputed check differs.
//
// The APB slave port and the register addresses are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module fhc_top
   import fhc_pkg::*;
(
   // Clock and reset
   input  wire  logic                  pclk,
   input  wire  logic                  presetn,
   // APB slave
   input  wire  logic [FHC_AW-1:0]     paddr,
   input  wire  logic                  psel,
   input  wire  logic                  penable,
   input  wire  logic                  pwrite,
   input  wire  logic [31:0]           pwdata,
   output logic       [31:0]           prdata,
   output logic                        pready,
   output logic                        pslverr,
   // Transmit side
   input  wire  logic                  tx_start,
   input  wire  logic                  tx_marker,
   input  wire  logic                  near_cell_loss_slow,
   input  wire  logic                  near_cell_loss_fast,
   output logic       [7:0]            tx_oct,
   output logic                        tx_oct_valid,
   output logic                        tx_oct_first,
   // Receive side
   input  wire  logic [7:0]            rx_oct,
   input  wire  logic                  rx_oct_valid,
   input  wire  logic                  rx_oct_first,
   output logic                        rx_hdr_ok,
   output logic                        rx_crc_err,
   output logic                        rx_sync_err,
   output logic                        rx_marker,
   output fhc_ind_t                    rx_ind
);
   import fhc_pkg::*;

   // =====================================================
   // Local functions
   function automatic logic [23:0] build_ctrl(input fhc_ind_t i,
                                              input logic     mk,
                                              input fhc_cfg_t c);
      logic [7:0] o1;
      logic [7:0] o2;
      logic [7:0] o3;
      logic [3:0] r;
      o1 = {i.trig, i.ack,                                   // [RL1] [RL2]
            i.path_one_fault, i.path_two_fault,
            i.path_three_fault, i.path_four_fault,           // [RL3] [RL6]
            1'b0,                                            // [RL4]
            mk};                                             // [RL5]
      o2 = {1'b0, i.far_signal_loss, i.far_carrier_one_loss,
            i.far_carrier_two_loss,                          // [RL10]
            i.far_frame_defect,                              // [RL11]
            i.extra_fault & {2{c.extra_en}},                 // [RL7] [RL12]
            1'b0};
      o3 = {1'b0, i.far_power_off,                           // [RL14]
            i.far_power_loss & c.remote_side,                // [RL15]
            i.prop,                                          // [RL16]
            1'b0};
      r = fhc_crc({o1, o2, o3} & FHC_CRC_MASK);              // [RL17] [RL18]
      o2[7] = r[3];                                          // [RL9] [RL19]
      o2[0] = r[2];                                          // [RL9]
      o3[7] = r[1];                                          // [RL13]
      o3[0] = r[0];                                          // [RL13] [RL19]
      return {o1, o2, o3};
   endfunction : build_ctrl

   function automatic fhc_ind_t parse_ctrl(input logic [23:0] m);
      fhc_ind_t i;
      i                      = '0;
      i.trig                 = m[23];
      i.ack                  = m[22];
      i.path_one_fault       = m[21];
      i.path_two_fault       = m[20];
      i.path_three_fault     = m[19];
      i.path_four_fault      = m[18];
      i.far_signal_loss      = m[14];
      i.far_carrier_one_loss = m[13];
      i.far_carrier_two_loss = m[12];
      i.far_frame_defect     = m[11];
      i.extra_fault          = m[10:9];
      i.far_power_off        = m[6];
      i.far_power_loss       = m[5];
      i.prop                 = m[4:1];
      return i;
   endfunction : parse_ctrl

   // =====================================================
   // Register state
   typedef enum logic {FHC_TX_IDLE, FHC_TX_SEND} fhc_tx_st_t;

   fhc_cfg_t              cfg_reg;
   fhc_ind_t              tx_ind_reg;
   logic                  crc_sticky_reg;
   logic                  sync_sticky_reg;
   logic                  good_sticky_reg;
   logic [FHC_CNT_W-1:0]  err_cnt_reg;
   logic [FHC_CNT_W-1:0]  good_cnt_reg;
   logic                  acc_wr;
   logic                  mapped;
   logic [31:0]           rd_next;

   assign acc_wr = psel & penable & pwrite & pready;

   always_comb begin
      mapped  = 1'b1;
      rd_next = 32'h0;
      case (paddr)
         FHC_CTRL:     rd_next = {{(32-FHC_CTRL_W){1'b0}}, cfg_reg};
         FHC_TX_IND:   rd_next = {{(32-FHC_IND_W){1'b0}}, tx_ind_reg};
         FHC_RX_IND:   rd_next = {{(32-FHC_IND_W){1'b0}}, rx_ind};
         FHC_STATUS:   rd_next = {29'h0, sync_sticky_reg, crc_sticky_reg,
                                  good_sticky_reg};
         FHC_ERR_CNT:  rd_next = {{(32-FHC_CNT_W){1'b0}}, err_cnt_reg};
         FHC_GOOD_CNT: rd_next = {{(32-FHC_CNT_W){1'b0}}, good_cnt_reg};
         default:      mapped  = 1'b0;
      endcase
   end

   // =====================================================
   // APB answer: one wait-free access phase after setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end else begin
         pready  <= psel & ~penable;
         pslverr <= psel & ~penable & ~mapped;
         if (psel && !penable) begin
            prdata <= pwrite ? 32'h0 : rd_next;
         end
      end
   end

   // =====================================================
   // Software-written registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg    <= FHC_CTRL_RST;
         tx_ind_reg <= '0;
      end else if (acc_wr && !pslverr) begin
         if (paddr == FHC_CTRL) begin
            cfg_reg <= pwdata[FHC_CTRL_W-1:0];
         end
         if (paddr == FHC_TX_IND) begin
            tx_ind_reg <= pwdata[FHC_IND_W-1:0];
         end
      end
   end

   // =====================================================
   // Transmit header sequencer
   fhc_tx_st_t  tx_st_reg;
   logic [31:0] tx_sh_reg;
   logic [2:0]  tx_idx_reg;
   fhc_ind_t    tx_eff;

   always_comb begin
      tx_eff = tx_ind_reg;
      tx_eff.path_one_fault = tx_ind_reg.path_one_fault
                            | (cfg_reg.cell_mode & near_cell_loss_slow);
      tx_eff.path_two_fault = tx_ind_reg.path_two_fault
                            | (cfg_reg.cell_mode & cfg_reg.dual_latency
                               & near_cell_loss_fast);        // [RL8]
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_st_reg    <= FHC_TX_IDLE;
         tx_sh_reg    <= 32'h0;
         tx_idx_reg   <= 3'h0;
         tx_oct       <= 8'h0;
         tx_oct_valid <= 1'b0;
         tx_oct_first <= 1'b0;
      end else begin
         case (tx_st_reg)
            FHC_TX_IDLE: begin
               tx_oct_first <= tx_start;
               tx_oct_valid <= tx_start;
               if (tx_start) begin
                  tx_oct     <= FHC_SYNC1;                    // [RL21]
                  tx_sh_reg  <= {FHC_SYNC2,
                                 build_ctrl(tx_eff, tx_marker, cfg_reg)};
                  tx_idx_reg <= 3'h1;
                  tx_st_reg  <= FHC_TX_SEND;
               end
            end
            FHC_TX_SEND: begin
               tx_oct       <= tx_sh_reg[31:24];              // [RL20]
               tx_sh_reg    <= {tx_sh_reg[23:0], 8'h0};
               tx_oct_valid <= 1'b1;
               tx_oct_first <= 1'b0;
               tx_idx_reg   <= tx_idx_reg + 3'h1;
               if (tx_idx_reg == 3'(FHC_HDR_LEN - 1)) begin
                  tx_st_reg <= FHC_TX_IDLE;
               end
            end
            default: begin
               tx_st_reg    <= FHC_TX_IDLE;
               tx_oct_valid <= 1'b0;
               tx_oct_first <= 1'b0;
            end
         endcase
      end
   end

   // =====================================================
   // Receive header collection and check
   logic [2:0]  rx_idx_reg;
   logic        rx_sync_reg;
   logic [15:0] rx_ctrl_reg;
   logic [23:0] rx_msg;
   logic [3:0]  rx_chk;
   logic        rx_eval;
   logic        rx_good;
   logic        rx_bad_crc;
   logic        rx_bad_sync;

   assign rx_msg  = {rx_ctrl_reg, rx_oct};
   assign rx_chk  = {rx_msg[15], rx_msg[8], rx_msg[7], rx_msg[0]};
   assign rx_eval = rx_oct_valid & ~rx_oct_first
                  & (rx_idx_reg == 3'(FHC_HDR_LEN - 1));
   assign rx_bad_sync = rx_eval & ~rx_sync_reg;
   assign rx_bad_crc  = rx_eval & rx_sync_reg
                      & (fhc_crc(rx_msg & FHC_CRC_MASK) != rx_chk); // [RL22]
   assign rx_good     = rx_eval & ~rx_bad_sync & ~rx_bad_crc;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_idx_reg  <= 3'h0;
         rx_sync_reg <= 1'b0;
         rx_ctrl_reg <= 16'h0;
      end else if (rx_oct_valid) begin
         if (rx_oct_first) begin
            rx_idx_reg  <= 3'h1;
            rx_sync_reg <= (rx_oct == FHC_SYNC1);             // [RL21]
         end else if (rx_idx_reg != 3'h0) begin
            if (rx_idx_reg == 3'h1) begin
               rx_sync_reg <= rx_sync_reg & (rx_oct == FHC_SYNC2);
            end else begin
               rx_ctrl_reg <= {rx_ctrl_reg[7:0], rx_oct};
            end
            rx_idx_reg <= (rx_idx_reg == 3'(FHC_HDR_LEN - 1))
                        ? 3'h0 : rx_idx_reg + 3'h1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_hdr_ok   <= 1'b0;
         rx_crc_err  <= 1'b0;
         rx_sync_err <= 1'b0;
         rx_marker   <= 1'b0;
         rx_ind      <= '0;
      end else begin
         rx_hdr_ok   <= rx_good;
         rx_crc_err  <= rx_bad_crc;
         rx_sync_err <= rx_bad_sync;
         rx_marker   <= rx_good & rx_msg[16];                 // [RL5]
         if (rx_good) begin
            rx_ind <= parse_ctrl(rx_msg);                     // [RL22]
         end
      end
   end

   // =====================================================
   // Status flags and counters; a hardware set beats a clear
   logic st_clr;
   logic cnt_clr_err;
   logic cnt_clr_good;

   assign st_clr       = acc_wr & (paddr == FHC_STATUS);
   assign cnt_clr_err  = acc_wr & (paddr == FHC_ERR_CNT);
   assign cnt_clr_good = acc_wr & (paddr == FHC_GOOD_CNT);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         good_sticky_reg <= 1'b0;
         crc_sticky_reg  <= 1'b0;
         sync_sticky_reg <= 1'b0;
      end else begin
         good_sticky_reg <= rx_good
                          | (good_sticky_reg & ~(st_clr & pwdata[0]));
         crc_sticky_reg  <= rx_bad_crc
                          | (crc_sticky_reg & ~(st_clr & pwdata[1]));
         sync_sticky_reg <= rx_bad_sync
                          | (sync_sticky_reg & ~(st_clr & pwdata[2]));
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         err_cnt_reg  <= '0;
         good_cnt_reg <= '0;
      end else begin
         if (cnt_clr_err) begin
            err_cnt_reg <= {{(FHC_CNT_W-1){1'b0}}, rx_bad_crc};
         end else if (rx_bad_crc && (err_cnt_reg != '1)) begin
            err_cnt_reg <= err_cnt_reg + 1'b1;
         end
         if (cnt_clr_good) begin
            good_cnt_reg <= {{(FHC_CNT_W-1){1'b0}}, rx_good};
         end else if (rx_good && (good_cnt_reg != '1)) begin
            good_cnt_reg <= good_cnt_reg + 1'b1;
         end
      end
   end

endmodule : fhc_top

`default_nettype wire

/* File: dv/fhc_peer.sv */
// Far-end header processor model and a shared check-bit helper
`timescale 1ns/1ns
`default_nettype none
package fhc_dv_pkg;
   // Remainder of message times D^4 over D^4 + D + 1
   function automatic logic [3:0] dv_crc(input logic [23:0] m);
      logic [27:0] v;
      v = {m & 24'hff7e7e, 4'h0};
      for (int i = 27; i >= 4; i--)
         if (v[i]) v[i-:5] = v[i-:5] ^ 5'h13;
      return v[3:0];
   endfunction : dv_crc
endpackage : fhc_dv_pkg

module fhc_peer (
   // Clock
   input  wire logic       pclk,
   // Octets from the block
   input  wire logic [7:0] tx_oct,
   input  wire logic       tx_oct_valid,
   input  wire logic       tx_oct_first,
   // Octets to the block
   output var  logic [7:0] rx_oct,
   output var  logic       rx_oct_valid,
   output var  logic       rx_oct_first
);
   logic [39:0] got;
   initial begin
      rx_oct       = 8'h5a;
      rx_oct_valid = 1'b0;
      rx_oct_first = 1'b0;
   end
   // Last header seen, first octet in the top byte
   always @(posedge pclk) begin
      if (tx_oct_valid) got <= {got[31:0], tx_oct};
   end
   // Released line shows a changing filler
   task automatic idle;
      @(posedge pclk);
      rx_oct       <= ~rx_oct;
      rx_oct_valid <= 1'b0;
      rx_oct_first <= 1'b0;
   endtask : idle
   // One header, octet 0 first, gap idle cycles between octets
   task automatic send(input logic [39:0] h, input int gap);
      for (int k = 4; k >= 0; k--) begin
         @(posedge pclk);
         rx_oct       <= h[8*k+:8];
         rx_oct_valid <= 1'b1;
         rx_oct_first <= (k == 4);
         if (k > 0) repeat (gap) idle();
      end
      idle();
   endtask : send
endmodule : fhc_peer
`default_nettype wire

/* File: dv/fhc_top_asserts.sv */
// Header timing and check-bit assertions bound to the top module
`timescale 1ns/1ns
`default_nettype none
module fhc_chk (
   // Clock and reset
   input wire logic             pclk,
   input wire logic             presetn,
   // Transmit side
   input wire logic             tx_start,
   input wire logic             tx_marker,
   input wire logic [7:0]       tx_oct,
   input wire logic             tx_oct_valid,
   input wire logic             tx_oct_first,
   // Receive side
   input wire logic             rx_oct_valid,
   input wire logic             rx_oct_first,
   input wire logic             rx_hdr_ok,
   input wire logic             rx_crc_err,
   input wire logic             rx_sync_err,
   input wire logic             rx_marker,
   input wire fhc_pkg::fhc_ind_t rx_ind
);
   import fhc_pkg::*;
   import fhc_dv_pkg::*;
   logic [7:0] o1, o2;
   // =====================================================
   // Last two transmitted octets
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         o1 <= 8'h00;
         o2 <= 8'h00;
      end else begin
         o1 <= tx_oct;
         o2 <= o1;
      end
   end
   // =====================================================
   // Assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   chk_sync_octets: assert property (
      tx_oct_first |-> (tx_oct_valid && tx_oct == FHC_SYNC1)
      ##1 (tx_oct == FHC_SYNC2)) else $error("bad sync octets");
   chk_header_length: assert property (
      tx_oct_first |-> tx_oct_valid[*5]) else $error("short header");
   chk_single_first: assert property (
      tx_oct_first |=> !tx_oct_first[*4]) else $error("extra first");
   chk_bit_six_zero: assert property (
      tx_oct_first ##2 1'b1 |-> !tx_oct[1]) else $error("reserved set");
   chk_marker_sent: assert property (
      tx_start && !tx_oct_valid |=> tx_oct_first
      ##2 (tx_oct[0] == $past(tx_marker, 3))) else $error("bad marker");
   chk_check_bits: assert property (
      tx_oct_first ##4 1'b1 |-> {o1[7], o1[0], tx_oct[7], tx_oct[0]}
      == dv_crc({o2, o1, tx_oct})) else $error("bad check bits");
   chk_rx_verdict: assert property (
      rx_oct_valid && rx_oct_first ##1 (rx_oct_valid && !rx_oct_first)[*4]
      |=> $onehot({rx_hdr_ok, rx_crc_err, rx_sync_err}))
      else $error("no single verdict");
   chk_ind_held: assert property (
      rx_crc_err || rx_sync_err |-> $stable(rx_ind))
      else $error("fields changed on bad header");
   chk_marker_good: assert property (
      rx_marker |-> rx_hdr_ok) else $error("marker on bad header");
   cover property (tx_oct_first);
   cover property (rx_crc_err);
   cover property (rx_marker);
endmodule : fhc_chk
bind fhc_top fhc_chk u_chk (.pclk, .presetn, .tx_start, .tx_marker,
   .tx_oct, .tx_oct_valid, .tx_oct_first, .rx_oct_valid, .rx_oct_first,
   .rx_hdr_ok, .rx_crc_err, .rx_sync_err, .rx_marker, .rx_ind);
`default_nettype wire

/* File: dv/test_frame_header_control_crc.sv */
// Self-checking bench for the frame header control octet block
`timescale 1ns/1ns
`default_nettype none
module test_frame_header_control_crc;
   import fhc_pkg::*;
   import fhc_dv_pkg::*;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr, tx_oct, rx_oct;
   logic [31:0] pwdata, prdata;
   logic tx_start, tx_marker, slow, fast, tx_oct_valid, tx_oct_first;
   logic rx_oct_valid, rx_oct_first, rx_hdr_ok, rx_crc_err, rx_sync_err;
   logic rx_marker;
   fhc_ind_t rx_ind;
   logic [39:0] h;
   int failures = 0, samples_checked = 0, cyc = 0;
   fhc_top dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
      .prdata, .pready, .pslverr, .tx_start, .tx_marker,
      .near_cell_loss_slow(slow), .near_cell_loss_fast(fast), .tx_oct,
      .tx_oct_valid, .tx_oct_first, .rx_oct, .rx_oct_valid, .rx_oct_first,
      .rx_hdr_ok, .rx_crc_err, .rx_sync_err, .rx_marker, .rx_ind);
   fhc_peer peer (.pclk, .tx_oct, .tx_oct_valid, .tx_oct_first, .rx_oct,
      .rx_oct_valid, .rx_oct_first);
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         failures++;
         complete_run();
      end
   end
   // =====================================================
   // Helpers
   task automatic complete_run;
      $display("Checked %0d, mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : complete_run
   task automatic chk(input string nm, input logic [39:0] g, e);
      samples_checked++;
      if (g !== e) begin
         failures++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   function automatic logic [39:0] exp_hdr(input logic [3:0] c,
      input logic [17:0] d, input logic mk, sl, fs);
      logic [7:0] a, b, e;
      logic [3:0] r;
      a = {d[17:16], d[15] | (c[2] & sl), d[14] | (c[2] & c[1] & fs),
           d[13:12], 1'b0, mk};
      b = {1'b0, d[11:8], d[5:4] & {2{c[0]}}, 1'b0};
      e = {1'b0, d[7], d[6] & c[3], d[3:0], 1'b0};
      r = dv_crc({a, b, e});
      b = {r[3], b[6:1], r[2]};
      e = {r[1], e[6:1], r[0]};
      return {FHC_SYNC1, FHC_SYNC2, a, b, e};
   endfunction : exp_hdr
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] wd, output logic [31:0] rd, output logic er);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (n >= 16) failures++;
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] d;
      logic er;
      apb(1'b1, a, v, d, er);
   endtask : wr
   task automatic rchk(input logic [7:0] a, input logic [31:0] v,
      input logic ee);
      logic [31:0] d;
      logic er;
      apb(1'b0, a, 32'h0, d, er);
      chk("read data", 40'(d), 40'(v));
      chk("slave error", 40'(er), 40'(ee));
   endtask : rchk
   // A second start in the first sending cycle must be ignored
   task automatic tx_chk(input logic [3:0] c, input logic [17:0] d,
      input logic mk, sl, fs);
      logic [39:0] w;
      wr(FHC_CTRL, 32'(c));
      wr(FHC_TX_IND, 32'(d));
      @(posedge pclk);
      tx_start  <= 1'b1;
      tx_marker <= mk;
      slow      <= sl;
      fast      <= fs;
      repeat (2) @(posedge pclk);
      tx_start <= 1'b0;
      repeat (5) @(posedge pclk);
      w = exp_hdr(c, d, mk, sl, fs);
      chk("tx header", peer.got, w);
      chk("tx idle", 40'(tx_oct_valid), 40'h0);
   endtask : tx_chk
   task automatic rx_chk(input logic [39:0] x, input int gap,
      input logic [2:0] v, input logic mk);
      logic [2:0] s;
      int n;
      peer.send(x, gap);
      n = 0;
      do begin
         @(posedge pclk);
         n++;
         s = {rx_hdr_ok, rx_crc_err, rx_sync_err};
      end while (s === 3'b000 && n < 8);
      chk("rx verdict", 40'(s), 40'(v));
      chk("rx marker", 40'(rx_marker), 40'(mk));
   endtask : rx_chk
   // =====================================================
   // Main sequence
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata} = '0;
      {tx_start, tx_marker, slow, fast} = '0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      rchk(FHC_CTRL, 32'h0, 1'b0);
      rchk(FHC_TX_IND, 32'h0, 1'b0);
      rchk(FHC_RX_IND, 32'h0, 1'b0);
      rchk(8'h18, 32'h0, 1'b1);
      tx_chk(4'h0, 18'h0, 1'b1, 1'b0, 1'b0);
      tx_chk(4'h0, 18'h3ffff, 1'b0, 1'b0, 1'b0);
      tx_chk(4'hf, 18'h3ffff, 1'b1, 1'b0, 1'b0);
      tx_chk(4'h6, 18'h0, 1'b0, 1'b1, 1'b1);
      tx_chk(4'h4, 18'h0, 1'b0, 1'b1, 1'b1);
      for (int i = 0; i < 18; i++)
         tx_chk(4'hf, 18'h1 << i, 1'b0, 1'b0, 1'b0);
      wr(FHC_CTRL, 32'h9);
      rchk(FHC_CTRL, 32'h9, 1'b0);
      h = exp_hdr(4'h9, 18'h2b5b7, 1'b1, 1'b0, 1'b0);
      rx_chk(h, 2, 3'b100, 1'b1);
      chk("rx fields", 40'(rx_ind), 40'h2b5b7);
      rx_chk(h ^ 40'h20_0000, 0, 3'b010, 1'b0);
      chk("rx held", 40'(rx_ind), 40'h2b5b7);
      rx_chk({8'h76, h[31:0]}, 1, 3'b001, 1'b0);
      rchk(FHC_STATUS, 32'h7, 1'b0);
      rchk(FHC_ERR_CNT, 32'h1, 1'b0);
      rchk(FHC_GOOD_CNT, 32'h1, 1'b0);
      rchk(FHC_RX_IND, 32'h2b5b7, 1'b0);
      wr(FHC_RX_IND, 32'h0);
      rchk(FHC_RX_IND, 32'h2b5b7, 1'b0);
      wr(FHC_STATUS, 32'h7);
      rchk(FHC_STATUS, 32'h0, 1'b0);
      wr(FHC_ERR_CNT, 32'h0);
      rchk(FHC_ERR_CNT, 32'h0, 1'b0);
      // Mid-run reset clears state and the transmitter restarts cleanly
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rchk(FHC_RX_IND, 32'h0, 1'b0);
      rchk(FHC_GOOD_CNT, 32'h0, 1'b0);
      rchk(FHC_CTRL, 32'h0, 1'b0);
      tx_chk(4'h2, 18'h155, 1'b1, 1'b0, 1'b0);
      complete_run();
   end
endmodule : test_frame_header_control_crc
`default_nettype wire
